// *** core/tic_regs.sv ***
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// - Bit 15 set disables interrupt nesting.
// - Accumulator A overflow trap sets its flag.
// - Accumulator B overflow trap sets its flag.
// - Separate catastrophic overflow flags per accumulator.
// - Per-accumulator overflow trap enables gate traps.
// - Shared enable gates catastrophic overflow traps.
// - Invalid shift math trap sets shift flag.
// - Divide by zero sets its flag.
// - DMA error trap sets DMA flag.
// - Any math trap sets math flag.
// - Address error trap sets address flag.
// - Stack error trap sets stack flag.
// - Oscillator failure trap sets oscillator flag.
// - Unimplemented control bits read as zero.
// - Alternate table select picks vector table.
// - Read-only status shows interrupt hold active.
// - Per-input polarity: one falling, zero rising.
// - Upper flag byte layout, bit 15 unused.
// - Lower flag byte layout, external 0 lowest.
// - Request flags read/write, reset to zero.
// - Hardware sets flags, software clears them.
// - Nesting disable locks CPU priority low bits.
module tic_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic accAOverflowEvt,
  input wire logic accBOverflowEvt,
  input wire logic accACatastrophicEvt,
  input wire logic accBCatastrophicEvt,
  input wire logic shiftErrorEvt,
  input wire logic divideZeroEvt,
  input wire logic dmaErrorEvt,
  input wire logic addressErrorEvt,
  input wire logic stackErrorEvt,
  input wire logic oscFailureEvt,
  input wire logic irqHoldActive,
  input wire logic [14:0] periphEvt,
  input wire logic [2:0] extPin,
  output logic nestingDisable,
  output logic altTableSelect,
  output logic [2:0] cpuPriorityLowBits,
  output logic mathTrap,
  output logic dmaTrap,
  output logic addressTrap,
  output logic stackTrap,
  output logic oscTrap,
  output logic [2:0] extEdge
);
  import tic_pkg::*;

  typedef struct packed {
    logic [15:0] trapCtrl;
    logic altTable;
    logic holdActive;
    logic [2:0] extPolarity;
    logic [15:0] reqFlags;
    logic [2:0] prio;
    logic [2:0] extPrev;
    logic [31:0] rdata;
    logic ready;
    logic slvErr;
    logic mathTrap;
    logic dmaTrap;
    logic addressTrap;
    logic stackTrap;
    logic oscTrap;
    logic [2:0] extEdge;
  } tic_state_t;

  tic_state_t st;
  tic_state_t next_st;

  // Decodes a bus address into {hit, index}; used by both read and write paths.
  function automatic logic [2:0] tic_decode(input logic [7:0] addr);
    logic [2:0] res;
    res = 3'h0;
    case (addr)
      TIC_OFF_TRAP_CTRL: res = {1'b1, TIC_IDX_TRAP};
      TIC_OFF_VECT_CTRL: res = {1'b1, TIC_IDX_VECT};
      TIC_OFF_REQ_FLAGS0: res = {1'b1, TIC_IDX_FLAGS};
      TIC_OFF_PRIO_CTRL: res = {1'b1, TIC_IDX_PRIO};
      default: res = 3'h0;
    endcase
    return res;
  endfunction

  logic [2:0] dec;
  logic wrEn;
  logic rdSetup;
  logic [15:0] laneMask;
  logic [15:0] trapSet;
  logic [2:0] edgeNow;
  logic [15:0] flagSet;
  logic [15:0] vectView;

  // Bus decode; a write lands only on the access edge where pready is sampled high.
  assign dec = tic_decode(paddr);
  assign wrEn = psel && penable && pwrite && st.ready;
  assign rdSetup = psel && !penable;
  assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign vectView = {st.altTable, st.holdActive, 11'h000, st.extPolarity};

  // Trap causes, gated by the enables where the trap itself is optional.
  always_comb begin
    trapSet = 16'h0000;
    trapSet[TIC_BIT_OVA_FLAG] = accAOverflowEvt && st.trapCtrl[TIC_BIT_OVA_TE];
    trapSet[TIC_BIT_OVB_FLAG] = accBOverflowEvt && st.trapCtrl[TIC_BIT_OVB_TE];
    trapSet[TIC_BIT_COVA_FLAG] = accACatastrophicEvt && st.trapCtrl[TIC_BIT_COV_TE];
    trapSet[TIC_BIT_COVB_FLAG] = accBCatastrophicEvt && st.trapCtrl[TIC_BIT_COV_TE];
    trapSet[TIC_BIT_SHIFT_FLAG] = shiftErrorEvt;
    trapSet[TIC_BIT_DIV0_FLAG] = divideZeroEvt;
    trapSet[TIC_BIT_DMA_FLAG] = dmaErrorEvt;
    trapSet[TIC_BIT_ADDR_FLAG] = addressErrorEvt;
    trapSet[TIC_BIT_STACK_FLAG] = stackErrorEvt;
    trapSet[TIC_BIT_OSC_FLAG] = oscFailureEvt;
    // Every enabled math-class cause also raises the general math flag.
    trapSet[TIC_BIT_MATH_FLAG] = trapSet[TIC_BIT_OVA_FLAG] || trapSet[TIC_BIT_OVB_FLAG] ||
      trapSet[TIC_BIT_COVA_FLAG] || trapSet[TIC_BIT_COVB_FLAG] ||
      shiftErrorEvt || divideZeroEvt;
  end

  // Edge detection on the three external inputs, one polarity bit each.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_edge
      assign edgeNow[gi] = st.extPolarity[gi] ? (st.extPrev[gi] && !extPin[gi]) :
        (!st.extPrev[gi] && extPin[gi]);
    end
  endgenerate

  // Peripheral events fill bits 14..1, external input 0 fills bit 0; bit 15 has no source.
  assign flagSet = {1'b0, periphEvt[13:0], edgeNow[0]} & TIC_MASK_FLAGS;

  // Next-state logic: software writes first, hardware sets afterwards so a set wins.
  always_comb begin
    next_st = st;
    next_st.mathTrap = trapSet[TIC_BIT_MATH_FLAG];
    next_st.dmaTrap = dmaErrorEvt;
    next_st.addressTrap = addressErrorEvt;
    next_st.stackTrap = stackErrorEvt;
    next_st.oscTrap = oscFailureEvt;
    next_st.extPrev = extPin;
    next_st.extEdge = edgeNow;
    next_st.holdActive = irqHoldActive;
    next_st.ready = psel && !penable;
    // The error flag is a one-cycle answer like pready; leaving it up would taint later transfers.
    next_st.slvErr = 1'b0;
    if (rdSetup) begin
      next_st.slvErr = !dec[2];
      case (dec[1:0])
        TIC_IDX_TRAP: next_st.rdata = {16'h0000, st.trapCtrl & TIC_MASK_TRAP};
        TIC_IDX_VECT: next_st.rdata = {16'h0000, vectView};
        TIC_IDX_FLAGS: next_st.rdata = {16'h0000, st.reqFlags & TIC_MASK_FLAGS};
        TIC_IDX_PRIO: next_st.rdata = {29'h0000000, st.prio};
        default: next_st.rdata = 32'h00000000;
      endcase
      if (!dec[2] || pwrite) begin
        next_st.rdata = 32'h00000000;
      end
    end
    if (wrEn && dec[2]) begin
      case (dec[1:0])
        TIC_IDX_TRAP: begin
          // Trap flags keep their value unless software writes them back.
          next_st.trapCtrl = (st.trapCtrl & ~(TIC_MASK_TRAP & laneMask)) |
            (pwdata[15:0] & TIC_MASK_TRAP & laneMask);
        end
        TIC_IDX_VECT: begin
          // Writes assign only the table select and polarity fields, so they cannot touch the hold status bit.
          if (pstrb[1]) begin
            next_st.altTable = pwdata[TIC_BIT_ALT_TABLE];
          end
          if (pstrb[0]) begin
            next_st.extPolarity = pwdata[TIC_BIT_EXT0_POL +: 3];
          end
        end
        TIC_IDX_FLAGS: begin
          next_st.reqFlags = (st.reqFlags & ~(TIC_MASK_FLAGS & laneMask)) |
            (pwdata[15:0] & TIC_MASK_FLAGS & laneMask);
        end
        TIC_IDX_PRIO: begin
          // The core may not change its own level while nesting is off.
          if (!st.trapCtrl[TIC_BIT_NEST_DIS] && pstrb[0]) begin
            next_st.prio = pwdata[2:0];
          end
        end
        default: begin
          next_st.prio = st.prio;
        end
      endcase
    end
    next_st.trapCtrl = next_st.trapCtrl | trapSet;
    next_st.reqFlags = next_st.reqFlags | flagSet;
  end

  // State register; all fields clear at reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.trapCtrl <= TIC_RST_TRAP;
      st.altTable <= TIC_RST_VECT[TIC_BIT_ALT_TABLE];
      st.extPolarity <= TIC_RST_VECT[2:0];
      st.reqFlags <= TIC_RST_FLAGS;
      st.prio <= TIC_RST_PRIO;
    end else begin
      st <= next_st;
    end
  end

  // All outputs come straight from the state register.
  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.slvErr;
  assign nestingDisable = st.trapCtrl[TIC_BIT_NEST_DIS];
  assign altTableSelect = st.altTable;
  assign cpuPriorityLowBits = st.prio;
  assign mathTrap = st.mathTrap;
  assign dmaTrap = st.dmaTrap;
  assign addressTrap = st.addressTrap;
  assign stackTrap = st.stackTrap;
  assign oscTrap = st.oscTrap;
  assign extEdge = st.extEdge;

  // Checks on the register behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic wrTrap;
  assign wrTrap = wrEn && dec[2] && dec[1:0] == TIC_IDX_TRAP;

  a_nest_write: assert property (wrTrap && pstrb[1] |=> nestingDisable == $past(pwdata[15]))
    else $error("nesting disable did not follow the write");
  a_ova_flag: assert property (accAOverflowEvt && st.trapCtrl[10] |=> st.trapCtrl[14] && st.trapCtrl[4] && mathTrap)
    else $error("accumulator A overflow flag not set");
  a_ovb_flag: assert property (accBOverflowEvt && st.trapCtrl[9] |=> st.trapCtrl[13] && mathTrap)
    else $error("accumulator B overflow flag not set");
  a_cov_flags: assert property (accACatastrophicEvt && !accBCatastrophicEvt && st.trapCtrl[8] && !st.trapCtrl[11]
      && !wrTrap |=> st.trapCtrl[12] && !st.trapCtrl[11])
    else $error("catastrophic flags not kept apart");
  a_ova_gated: assert property (accAOverflowEvt && !st.trapCtrl[10] && !st.trapCtrl[14] && !wrTrap
      |=> !st.trapCtrl[14])
    else $error("overflow trap raised while disabled");
  a_cov_gated: assert property (accBCatastrophicEvt && !st.trapCtrl[8] && !st.trapCtrl[11] && !wrTrap
      |=> !st.trapCtrl[11])
    else $error("catastrophic trap raised while disabled");
  a_shift_flag: assert property (shiftErrorEvt |=> st.trapCtrl[7] && st.trapCtrl[4])
    else $error("shift error flag not set");
  a_div_flag: assert property (divideZeroEvt |=> st.trapCtrl[6] && mathTrap)
    else $error("divide by zero flag not set");
  a_dma_flag: assert property (dmaErrorEvt |=> st.trapCtrl[5] && dmaTrap)
    else $error("dma error flag not set");
  a_math_only: assert property (!accAOverflowEvt && !accBOverflowEvt && !accACatastrophicEvt && !accBCatastrophicEvt
      && !shiftErrorEvt && !divideZeroEvt |=> !mathTrap)
    else $error("math trap without a math cause");
  a_addr_flag: assert property (addressErrorEvt |=> st.trapCtrl[3] && addressTrap)
    else $error("address error flag not set");
  a_stack_flag: assert property (stackErrorEvt |=> st.trapCtrl[2] && stackTrap)
    else $error("stack error flag not set");
  a_osc_flag: assert property (oscFailureEvt |=> st.trapCtrl[1] && oscTrap)
    else $error("oscillator failure flag not set");
  a_unimpl_zero: assert property (pready && psel && !pwrite && $past(dec[1:0]) != TIC_IDX_PRIO
      |-> prdata[0] == 1'b0 || $past(dec[1:0]) != TIC_IDX_TRAP)
    else $error("unimplemented trap bit read as one");
  a_vect_gap: assert property (pready && psel && !pwrite && $past(dec) == {1'b1, TIC_IDX_VECT}
      |-> prdata[31:16] == 16'h0000 && prdata[13:3] == 11'h000)
    else $error("unimplemented vector bits read as one");
  a_alt_table: assert property (wrEn && dec == {1'b1, TIC_IDX_VECT} && pstrb[1]
      |=> altTableSelect == $past(pwdata[15]))
    else $error("alternate table select did not follow the write");
  a_hold_status: assert property (##1 st.holdActive == $past(irqHoldActive))
    else $error("hold status does not track the core");
  a_ext_edge: assert property (!st.extPolarity[0] && !extPin[0] ##1 extPin[0] && !st.extPolarity[0]
      |=> extEdge[0] && st.reqFlags[0])
    else $error("rising edge on external input 0 missed");
  a_ext_fall: assert property (st.extPolarity[1] && extPin[1] ##1 !extPin[1] && st.extPolarity[1]
      |=> extEdge[1])
    else $error("falling edge on external input 1 missed");
  a_flag_top: assert property (st.reqFlags[15] == 1'b0)
    else $error("unused flag bit set");
  a_flag_set: assert property (periphEvt[13] |=> st.reqFlags[14])
    else $error("peripheral event did not set its flag");
  a_flag_clear: assert property (wrEn && dec == {1'b1, TIC_IDX_FLAGS} && pstrb == 4'hF && periphEvt == 15'h0000
      && !edgeNow[0] |=> st.reqFlags == ($past(pwdata[15:0]) & 16'h7FFF))
    else $error("flag write not stored");
  a_prio_lock: assert property (wrEn && dec == {1'b1, TIC_IDX_PRIO} && nestingDisable
      |=> $stable(cpuPriorityLowBits))
    else $error("priority bits changed while locked");
  a_trap_sticky: assert property (st.trapCtrl[3] && !wrTrap |=> st.trapCtrl[3])
    else $error("address trap flag dropped without a write");

  // A later trap of another kind must not disturb a flag that is already up.
  a_sticky_other: assert property (st.trapCtrl[3] && stackErrorEvt && !wrTrap
      |=> st.trapCtrl[3] && st.trapCtrl[2])
    else $error("address flag lost on a later stack trap");

  // Bus handshake: pready answers each setup cycle once and never stands longer.
  a_ready_answer: assert property (psel && !penable
      |=> pready)
    else $error("no ready after a setup cycle");
  a_ready_once: assert property (pready
      |=> !pready)
    else $error("ready stood for more than one cycle");

  // Error response: only an unmapped address raises it, and only beside pready.
  a_err_unmapped: assert property (psel && !penable && !dec[2]
      |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  a_err_quiet: assert property (!pready
      |-> !pslverr)
    else $error("error response outside the access cycle");
  a_err_mapped: assert property (psel && !penable && dec[2]
      |=> !pslverr)
    else $error("mapped access refused");

  // Writes that are allowed must land exactly as written; the hold status ignores them.
  a_prio_open: assert property (wrEn && dec == {1'b1, TIC_IDX_PRIO} && !nestingDisable && pstrb[0]
      |=> cpuPriorityLowBits == $past(pwdata[2:0]))
    else $error("priority write lost while unlocked");
  a_pol_write: assert property (wrEn && dec == {1'b1, TIC_IDX_VECT} && pstrb[0]
      |=> st.extPolarity == $past(pwdata[2:0]))
    else $error("polarity write lost");
  a_hold_ro: assert property (wrEn && dec == {1'b1, TIC_IDX_VECT} && !irqHoldActive
      |=> !st.holdActive)
    else $error("hold status follows a bus write");

  // Gated overflow causes must stay silent while their enables are off.
  a_ovb_gated: assert property (accBOverflowEvt && !st.trapCtrl[9] && !st.trapCtrl[13] && !wrTrap
      |=> !st.trapCtrl[13])
    else $error("accumulator B overflow trap raised while disabled");
  a_cova_gated: assert property (accACatastrophicEvt && !st.trapCtrl[8] && !st.trapCtrl[12] && !wrTrap
      |=> !st.trapCtrl[12])
    else $error("accumulator A catastrophic trap raised while disabled");

  // Trap pulses only follow their own cause, one cycle behind it.
  a_dma_pulse: assert property (!dmaErrorEvt
      |=> !dmaTrap)
    else $error("dma trap pulse without a cause");
  a_addr_pulse: assert property (!addressErrorEvt
      |=> !addressTrap)
    else $error("address trap pulse without a cause");
  a_stack_pulse: assert property (!stackErrorEvt
      |=> !stackTrap)
    else $error("stack trap pulse without a cause");
  a_osc_pulse: assert property (!oscFailureEvt
      |=> !oscTrap)
    else $error("oscillator trap pulse without a cause");

  // Edge detection: the edge opposite to the selected one, or a steady input, raises nothing.
  a_ext_quiet: assert property (!st.extPolarity[0] && extPin[0] ##1 !extPin[0] && !st.extPolarity[0]
      |=> !extEdge[0])
    else $error("falling edge on external input 0 taken while rising selected");
  a_ext_still: assert property (extPin == $past(extPin)
      |=> extEdge == 3'h0)
    else $error("edge pulse while the inputs were steady");

  // Request flags stay up until software writes them down; unused trap bit 0 stays clear.
  a_flag_keep: assert property (st.reqFlags[14] && !(wrEn && dec == {1'b1, TIC_IDX_FLAGS})
      |=> st.reqFlags[14])
    else $error("request flag dropped without a write");
  a_trap_bit0: assert property (st.trapCtrl[0] == 1'b0)
    else $error("unused trap bit set");

endmodule

// *** shared/tic_pkg.sv ***
package tic_pkg;

  // Register word offsets on the APB bus.
  localparam logic [7:0] TIC_OFF_TRAP_CTRL = 8'h00;
  localparam logic [7:0] TIC_OFF_VECT_CTRL = 8'h04;
  localparam logic [7:0] TIC_OFF_REQ_FLAGS0 = 8'h08;
  localparam logic [7:0] TIC_OFF_PRIO_CTRL = 8'h0C;

  // Register indices returned by the address decoder.
  localparam logic [1:0] TIC_IDX_TRAP = 2'h0;
  localparam logic [1:0] TIC_IDX_VECT = 2'h1;
  localparam logic [1:0] TIC_IDX_FLAGS = 2'h2;
  localparam logic [1:0] TIC_IDX_PRIO = 2'h3;

  // Field positions in trap_and_nesting_control.
  localparam int TIC_BIT_NEST_DIS = 15;
  localparam int TIC_BIT_OVA_FLAG = 14;
  localparam int TIC_BIT_OVB_FLAG = 13;
  localparam int TIC_BIT_COVA_FLAG = 12;
  localparam int TIC_BIT_COVB_FLAG = 11;
  localparam int TIC_BIT_OVA_TE = 10;
  localparam int TIC_BIT_OVB_TE = 9;
  localparam int TIC_BIT_COV_TE = 8;
  localparam int TIC_BIT_SHIFT_FLAG = 7;
  localparam int TIC_BIT_DIV0_FLAG = 6;
  localparam int TIC_BIT_DMA_FLAG = 5;
  localparam int TIC_BIT_MATH_FLAG = 4;
  localparam int TIC_BIT_ADDR_FLAG = 3;
  localparam int TIC_BIT_STACK_FLAG = 2;
  localparam int TIC_BIT_OSC_FLAG = 1;

  // Field positions in vector_and_edge_control.
  localparam int TIC_BIT_ALT_TABLE = 15;
  localparam int TIC_BIT_HOLD_ACTIVE = 14;
  localparam int TIC_BIT_EXT0_POL = 0;

  // Field position of the external interrupt 0 request flag.
  localparam int TIC_BIT_EXT0_FLAG = 0;

  // Writable bit masks and reset values.
  localparam logic [15:0] TIC_MASK_TRAP = 16'hFFFE;
  localparam logic [15:0] TIC_MASK_VECT = 16'h8007;
  localparam logic [15:0] TIC_MASK_FLAGS = 16'h7FFF;
  localparam logic [15:0] TIC_RST_TRAP = 16'h0000;
  localparam logic [15:0] TIC_RST_VECT = 16'h0000;
  localparam logic [15:0] TIC_RST_FLAGS = 16'h0000;
  localparam logic [2:0] TIC_RST_PRIO = 3'h0;

endpackage

// *** sim/tic_event_src.sv ***
`timescale 1ns/1ps
module tic_event_src (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fire,
  input wire logic [24:0] fireVec,
  input wire logic holdLvl,
  input wire logic [2:0] pinLvl,
  output logic [9:0] trapEvt,
  output logic [14:0] periphEvt,
  output logic irqHoldActive,
  output logic [2:0] extPin
);
  // Event requests last only while fire is high, one cycle per fire_evt, so a stuck level can never hide a missed set.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trapEvt <= 10'h000;
      periphEvt <= 15'h0000;
      irqHoldActive <= 1'b0;
      extPin <= 3'h0;
    end else begin
      trapEvt <= fire ? fireVec[9:0] : 10'h000;
      periphEvt <= fire ? fireVec[24:10] : 15'h0000;
      irqHoldActive <= holdLvl;
      extPin <= pinLvl;
    end
  end
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import tic_pkg::*;
  typedef struct packed {logic [7:0] addr; logic [15:0] pre; logic [24:0] vec; logic [15:0] exp;} tic_row_t;
  logic clk, resetn, psel, penable, pwrite, fire, holdLvl, pready, pslverr, nestingDisable, altTableSelect;
  logic mathTrap, dmaTrap, addressTrap, stackTrap, oscTrap, irqHoldActive;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, edgeCnt;
  logic [3:0] pstrb;
  logic [24:0] fireVec;
  logic [2:0] pinLvl, extPin, extEdge, cpuPriorityLowBits;
  logic [9:0] trapEvt;
  logic [14:0] periphEvt;
  logic er;
  int miscompares = 0;
  int n_checks = 0;
  // Ordinary cases: enables written first, one burst of events, expected register word.
  tic_row_t rows [15] = '{
    '{TIC_OFF_TRAP_CTRL, 16'h0000, 25'h0000001, 16'h0000}, '{TIC_OFF_TRAP_CTRL, 16'h0400, 25'h0000001, 16'h4410},
    '{TIC_OFF_TRAP_CTRL, 16'h0200, 25'h0000002, 16'h2210}, '{TIC_OFF_TRAP_CTRL, 16'h0100, 25'h0000004, 16'h1110},
    '{TIC_OFF_TRAP_CTRL, 16'h0100, 25'h0000008, 16'h0910}, '{TIC_OFF_TRAP_CTRL, 16'h0000, 25'h000000E, 16'h0000},
    '{TIC_OFF_TRAP_CTRL, 16'h0000, 25'h0000010, 16'h0090}, '{TIC_OFF_TRAP_CTRL, 16'h0000, 25'h0000020, 16'h0050},
    '{TIC_OFF_TRAP_CTRL, 16'h0000, 25'h0000040, 16'h0020}, '{TIC_OFF_TRAP_CTRL, 16'h0000, 25'h0000080, 16'h0008},
    '{TIC_OFF_TRAP_CTRL, 16'h0000, 25'h0000100, 16'h0004}, '{TIC_OFF_TRAP_CTRL, 16'h0000, 25'h0000200, 16'h0002},
    '{TIC_OFF_REQ_FLAGS0, 16'h0000, 25'h0555400, 16'h2AAA}, '{TIC_OFF_REQ_FLAGS0, 16'h0000, 25'h0AAA800, 16'h5554},
    '{TIC_OFF_REQ_FLAGS0, 16'h0000, 25'h1FFFC00, 16'h7FFE}};

  tic_regs tic_regs_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .accAOverflowEvt(trapEvt[0]), .accBOverflowEvt(trapEvt[1]), .accACatastrophicEvt(trapEvt[2]),
    .accBCatastrophicEvt(trapEvt[3]), .shiftErrorEvt(trapEvt[4]), .divideZeroEvt(trapEvt[5]),
    .dmaErrorEvt(trapEvt[6]), .addressErrorEvt(trapEvt[7]), .stackErrorEvt(trapEvt[8]),
    .oscFailureEvt(trapEvt[9]), .irqHoldActive(irqHoldActive), .periphEvt(periphEvt), .extPin(extPin),
    .nestingDisable(nestingDisable), .altTableSelect(altTableSelect), .cpuPriorityLowBits(cpuPriorityLowBits),
    .mathTrap(mathTrap), .dmaTrap(dmaTrap), .addressTrap(addressTrap), .stackTrap(stackTrap),
    .oscTrap(oscTrap), .extEdge(extEdge));
  tic_event_src tic_event_src_i (.clk(clk), .resetn(resetn), .fire(fire), .fireVec(fireVec),
    .holdLvl(holdLvl), .pinLvl(pinLvl), .trapEvt(trapEvt), .periphEvt(periphEvt),
    .irqHoldActive(irqHoldActive), .extPin(extPin));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Edge pulses are tallied here because they last a single cycle and are easy to miss by polling.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) edgeCnt <= 32'h0;
    else edgeCnt <= edgeCnt + $countones(extEdge);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%08h exp=%08h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen, then released for one idle cycle.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic fire_evt(input logic [24:0] v);
    fireVec <= v;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic pin_step(input logic [2:0] lvl, input logic [15:0] expFlags);
    pinLvl <= lvl;
    repeat (3) @(posedge clk);
    apb(1'b0, TIC_OFF_REQ_FLAGS0, 32'h0);
    chk(rd, {16'h0000, expFlags});
    apb(1'b1, TIC_OFF_REQ_FLAGS0, 32'h0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // A hang in the bus handshake ends the run here.
  initial begin
    #40000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, fire, holdLvl} = 5'h00;
    {paddr, pwdata, fireVec, pinLvl} = 68'h0;
    pstrb = 4'hF;
    resetn = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    $display("reset values done");
    for (int i = 0; i < 15; i++) begin
      apb(1'b1, TIC_OFF_TRAP_CTRL, {16'h0000, rows[i].pre});
      fire_evt(rows[i].vec);
      apb(1'b0, rows[i].addr, 32'h0);
      chk(rd, {16'h0000, rows[i].exp});
      apb(1'b1, TIC_OFF_TRAP_CTRL, 32'h0);
      apb(1'b1, TIC_OFF_REQ_FLAGS0, 32'h0);
      $display("row %0d done", i);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[31:1], er}, 32'h1);
    $display("unmapped done");
    apb(1'b1, TIC_OFF_VECT_CTRL, 32'hFFFF);
    apb(1'b0, TIC_OFF_VECT_CTRL, 32'h0);
    chk(rd, 32'h8007);
    chk({31'h0, altTableSelect}, 32'h1);
    holdLvl <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, TIC_OFF_VECT_CTRL, 32'h0);
    chk(rd, 32'hC007);
    holdLvl <= 1'b0;
    apb(1'b1, TIC_OFF_VECT_CTRL, 32'h0);
    $display("vector control done");
    apb(1'b1, TIC_OFF_TRAP_CTRL, 32'hFFFF);
    apb(1'b0, TIC_OFF_TRAP_CTRL, 32'h0);
    chk(rd, 32'hFFFE);
    chk({31'h0, nestingDisable}, 32'h1);
    apb(1'b1, TIC_OFF_PRIO_CTRL, 32'h7);
    chk({29'h0, cpuPriorityLowBits}, 32'h0);
    apb(1'b1, TIC_OFF_TRAP_CTRL, 32'h0);
    apb(1'b1, TIC_OFF_PRIO_CTRL, 32'h7);
    chk({29'h0, cpuPriorityLowBits}, 32'h7);
    $display("nesting lock done");
    pstrb <= 4'h1;
    apb(1'b1, TIC_OFF_TRAP_CTRL, 32'hFFFF);
    pstrb <= 4'hF;
    apb(1'b0, TIC_OFF_TRAP_CTRL, 32'h0);
    chk(rd, 32'h00FE);
    apb(1'b1, TIC_OFF_TRAP_CTRL, 32'h0);
    $display("byte lanes done");
    fire_evt(25'h0000080);
    fire_evt(25'h0000100);
    apb(1'b0, TIC_OFF_TRAP_CTRL, 32'h0);
    chk(rd, 32'h000C);
    apb(1'b1, TIC_OFF_TRAP_CTRL, 32'h0);
    apb(1'b0, TIC_OFF_TRAP_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("sticky flags done");
    pin_step(3'h7, 16'h0001);
    pin_step(3'h0, 16'h0000);
    apb(1'b1, TIC_OFF_VECT_CTRL, 32'h0007);
    pin_step(3'h7, 16'h0000);
    pin_step(3'h0, 16'h0001);
    chk(edgeCnt, 32'h6);
    $display("edge polarity done");
    apb(1'b1, TIC_OFF_VECT_CTRL, 32'h8000);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk({31'h0, altTableSelect}, 32'h0);
    apb(1'b0, TIC_OFF_VECT_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule
